// ===== design/cfe_params.svh
`ifndef CFE_PARAMS_SVH
`define CFE_PARAMS_SVH

// AXI4-Lite register byte offsets.
`define CFE_OFS_CTRL 4'h0
`define CFE_OFS_OCTH 4'h4
`define CFE_OFS_OVTH 4'h8
`define CFE_OFS_OTTH 4'hC
`define CFE_OFS_STAT 5'h10
`define CFE_OFS_IRQS 5'h14
`define CFE_OFS_IRQM 5'h18

// Control register fields.
`define CFE_CTRL_OCLATCH 0
`define CFE_CTRL_OVLATCH 1
`define CFE_CTRL_OTLATCH 2
`define CFE_CTRL_PRIPOS 3
`define CFE_CTRL_SECUSE 4
`define CFE_CTRL_SECPOS 5
`define CFE_CTRL_RESET 6'h00

// Threshold reset values.
`define CFE_OCTH_RESET 16'hFFFF
`define CFE_OVTH_RESET 16'hFFFF
`define CFE_OTTH_RESET 16'hFFFF

// Timing at 50 MHz.
`define CFE_CLK_MHZ 50
`define CFE_FILT_US 120
`define CFE_FILT_CYC (`CFE_FILT_US * `CFE_CLK_MHZ)
`define CFE_LATCH_US 1000000
`define CFE_LATCH_CYC (`CFE_LATCH_US * `CFE_CLK_MHZ)
`define CFE_RETRY_CYC 32'd50000

`endif

// ===== design/cfe_pkg.sv
package cfe_pkg;
  typedef enum logic [1:0]
  {
    CFE_RUN = 2'b00,
    CFE_RETRY = 2'b01,
    CFE_LATCHED = 2'b10
  } cfe_state_t;
endpackage

// ===== design/cfe_filt_if.sv
`timescale 1ns/1ps
interface cfe_filt_if;
  logic rawPin;
  logic stable;
  modport filt (input rawPin, output stable);
  modport user (output rawPin, input stable);
endinterface

// ===== design/cfe_pin_filter.sv
`timescale 1ns/1ps
`include "cfe_params.svh"
module cfe_pin_filter
  import cfe_pkg::*;
#(
  parameter logic [31:0] FILT_CYC = `CFE_FILT_CYC
)
(
  input wire logic clock,
  input wire logic reset,
  cfe_filt_if.filt port
);
  logic sync1;
  logic sync2;
  logic sync3;
  logic [31:0] holdCount;

  // Three-stage synchroniser; only the last two are compared.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end
    else
    begin
      sync1 <= port.rawPin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A new level must hold the full window before it is accepted.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      holdCount <= 32'h0;
      port.stable <= 1'b0;
    end
    else if (sync2 != sync3 || sync3 == port.stable)
    begin
      holdCount <= 32'h0;
    end
    else if (holdCount >= FILT_CYC - 32'h1)
    begin
      holdCount <= 32'h0;
      port.stable <= sync3;
    end
    else
    begin
      holdCount <= holdCount + 32'h1;
    end
  end

  property p_short_ignored;
    @(posedge clock) disable iff (reset)
      $changed(port.stable) |-> $past(holdCount) == FILT_CYC - 32'h1;
  endproperty
  a_short_ignored: assert property (p_short_ignored)
    else $error("Enable level accepted before filter window.");
endmodule

// ===== design/cfe_top.sv
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cfe_params.svh"
module cfe_top
  import cfe_pkg::*;
#(
  parameter logic [31:0] FILT_CYC = `CFE_FILT_CYC,
  parameter logic [31:0] LATCH_CYC = `CFE_LATCH_CYC,
  parameter logic [31:0] RETRY_CYC = `CFE_RETRY_CYC
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic primaryEnablePin,
  input wire logic secondaryEnableInput,
  input wire logic [15:0] outputCurrent,
  input wire logic [15:0] outputVoltage,
  input wire logic [15:0] moduleTemp,
  output logic outputEnable,
  output logic irq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------------
  // Registers and enable filters
  // ----------------------------------------------------------------
  logic [5:0] ctrl;
  logic [15:0] ocThresh;
  logic [15:0] ovThresh;
  logic [15:0] otThresh;
  logic [2:0] irqStatus;
  logic [2:0] irqMask;
  cfe_state_t ocState;
  cfe_state_t ovState;
  cfe_state_t otState;
  cfe_filt_if priIf();
  cfe_filt_if secIf();
  logic priActive;
  logic secActive;
  logic priPrev;
  logic [31:0] offCount;
  logic latchClear;
  logic [31:0] retryCount;
  logic ocTrip;
  logic ovTrip;
  logic otTrip;
  logic faultBlock;
  logic [2:0] newFault;

  assign priIf.rawPin = primaryEnablePin;
  assign secIf.rawPin = secondaryEnableInput;

  cfe_pin_filter #(.FILT_CYC(FILT_CYC)) u_pri (.clock(clock), .reset(reset), .port(priIf));
  cfe_pin_filter #(.FILT_CYC(FILT_CYC)) u_sec (.clock(clock), .reset(reset), .port(secIf));

  // Polarity: positive means high enables, negative means low enables.
  assign priActive = ctrl[`CFE_CTRL_PRIPOS] ? priIf.stable : ~priIf.stable;
  assign secActive = !ctrl[`CFE_CTRL_SECUSE] ||
                     (ctrl[`CFE_CTRL_SECPOS] ? secIf.stable : ~secIf.stable);

  assign ocTrip = outputCurrent > ocThresh;
  assign ovTrip = outputVoltage > ovThresh;
  assign otTrip = moduleTemp > otThresh;

  // ----------------------------------------------------------------
  // Latch release by holding primary enable off for one second
  // ----------------------------------------------------------------
  // Counting starts on the filtered off level, so bounce cannot clear a latch.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      offCount <= 32'h0;
      latchClear <= 1'b0;
      priPrev <= 1'b0;
    end
    else
    begin
      priPrev <= priActive;
      latchClear <= 1'b0;
      if (priActive)
      begin
        offCount <= 32'h0;
        latchClear <= !priPrev && offCount >= LATCH_CYC;
      end
      else if (offCount < LATCH_CYC)
      begin
        offCount <= offCount + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Restart interval timer shared by the over-current and over-voltage retry loops
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      retryCount <= 32'h0;
    end
    else if (ocState == CFE_RETRY || ovState == CFE_RETRY)
    begin
      retryCount <= (retryCount >= RETRY_CYC - 32'h1) ? 32'h0 : retryCount + 32'h1;
    end
    else
    begin
      retryCount <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Fault state machines, one per fault
  // ----------------------------------------------------------------
  // Over-current: hiccup retries after the interval; latched holds until cleared.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ocState <= CFE_RUN;
    end
    else
    begin
      case (ocState)
        CFE_RUN:
          if (ocTrip)
            ocState <= ctrl[`CFE_CTRL_OCLATCH] ? CFE_LATCHED : CFE_RETRY;
        CFE_RETRY:
          if (retryCount == RETRY_CYC - 32'h1)
            ocState <= CFE_RUN;
        CFE_LATCHED:
          if (latchClear)
            ocState <= CFE_RUN;
        default:
          ocState <= CFE_RUN;
      endcase
    end
  end

  // Over-voltage: same hiccup or latch policy as over-current.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ovState <= CFE_RUN;
    end
    else
    begin
      case (ovState)
        CFE_RUN:
          if (ovTrip)
            ovState <= ctrl[`CFE_CTRL_OVLATCH] ? CFE_LATCHED : CFE_RETRY;
        CFE_RETRY:
          if (retryCount == RETRY_CYC - 32'h1)
            ovState <= CFE_RUN;
        CFE_LATCHED:
          if (latchClear)
            ovState <= CFE_RUN;
        default:
          ovState <= CFE_RUN;
      endcase
    end
  end

  // Over-temperature: auto-recovery waits for temperature to fall back.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      otState <= CFE_RUN;
    end
    else
    begin
      case (otState)
        CFE_RUN:
          if (otTrip)
            otState <= ctrl[`CFE_CTRL_OTLATCH] ? CFE_LATCHED : CFE_RETRY;
        CFE_RETRY:
          if (!otTrip)
            otState <= CFE_RUN;
        CFE_LATCHED:
          if (latchClear)
            otState <= CFE_RUN;
        default:
          otState <= CFE_RUN;
      endcase
    end
  end

  // A trip blocks the output in the same cycle, before the state registers.
  assign faultBlock = ocState != CFE_RUN || ovState != CFE_RUN || otState != CFE_RUN ||
                      ocTrip || ovTrip || otTrip;

  // Output gate, registered.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      outputEnable <= 1'b0;
    end
    else
    begin
      outputEnable <= priActive && secActive && !faultBlock;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------
  logic wrFire;
  logic [31:0] wrAddr;
  logic [31:0] wrData;
  assign newFault = {otTrip && otState == CFE_RUN, ovTrip && ovState == CFE_RUN,
                     ocTrip && ocState == CFE_RUN};

  // Write-one-to-clear; a new event in the same cycle wins over the clear.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      irqStatus <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      if (wrFire && wrAddr == {27'h0, `CFE_OFS_IRQS})
        irqStatus <= (irqStatus & ~wrData[2:0]) | newFault;
      else
        irqStatus <= irqStatus | newFault;
      irq <= |(irqStatus & irqMask);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic awHeld;
  logic wHeld;
  logic [3:0] wrStrb;
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;
  // The ready outputs are flops; the held flags are only their inverse.
  assign awHeld = !s_axi_awready;
  assign wHeld = !s_axi_wready;

  // Address and data are captured independently, in either order.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      wrAddr <= 32'h0;
      wrData <= 32'h0;
      wrStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !awHeld)
      begin
        s_axi_awready <= 1'b0;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld)
      begin
        s_axi_wready <= 1'b0;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrAddr[31:2] <= 30'h6) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register writes; retry is the default for every fault.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ctrl <= `CFE_CTRL_RESET;
      ocThresh <= `CFE_OCTH_RESET;
      ovThresh <= `CFE_OVTH_RESET;
      otThresh <= `CFE_OTTH_RESET;
      irqMask <= 3'h0;
    end
    else if (wrFire && wrStrb[0])
    begin
      case (wrAddr[31:0])
        {28'h0, `CFE_OFS_CTRL}: ctrl <= wrData[5:0];
        {28'h0, `CFE_OFS_OCTH}: ocThresh[7:0] <= wrData[7:0];
        {28'h0, `CFE_OFS_OVTH}: ovThresh[7:0] <= wrData[7:0];
        {28'h0, `CFE_OFS_OTTH}: otThresh[7:0] <= wrData[7:0];
        {27'h0, `CFE_OFS_IRQM}: irqMask <= wrData[2:0];
        default: ;
      endcase
      if (wrStrb[1])
      begin
        case (wrAddr[31:0])
          {28'h0, `CFE_OFS_OCTH}: ocThresh[15:8] <= wrData[15:8];
          {28'h0, `CFE_OFS_OVTH}: ovThresh[15:8] <= wrData[15:8];
          {28'h0, `CFE_OFS_OTTH}: otThresh[15:8] <= wrData[15:8];
          default: ;
        endcase
      end
    end
    else if (wrFire && wrStrb[1])
    begin
      case (wrAddr[31:0])
        {28'h0, `CFE_OFS_OCTH}: ocThresh[15:8] <= wrData[15:8];
        {28'h0, `CFE_OFS_OVTH}: ovThresh[15:8] <= wrData[15:8];
        {28'h0, `CFE_OFS_OTTH}: otThresh[15:8] <= wrData[15:8];
        default: ;
      endcase
    end
  end

  // Reads answer in the same cycle the address is taken; arready and rvalid rise together.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          {28'h0, `CFE_OFS_CTRL}: s_axi_rdata <= {26'h0, ctrl};
          {28'h0, `CFE_OFS_OCTH}: s_axi_rdata <= {16'h0, ocThresh};
          {28'h0, `CFE_OFS_OVTH}: s_axi_rdata <= {16'h0, ovThresh};
          {28'h0, `CFE_OFS_OTTH}: s_axi_rdata <= {16'h0, otThresh};
          {27'h0, `CFE_OFS_STAT}: s_axi_rdata <= {25'h0, outputEnable, otState, ovState,
                                                  ocState};
          {27'h0, `CFE_OFS_IRQS}: s_axi_rdata <= {29'h0, irqStatus};
          {27'h0, `CFE_OFS_IRQM}: s_axi_rdata <= {29'h0, irqMask};
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_oc_off;
    @(posedge clock) disable iff (reset)
      ocTrip |=> !outputEnable;
  endproperty
  a_oc_off: assert property (p_oc_off)
    else $error("Output stayed on during over-current.");

  property p_retry_back;
    @(posedge clock) disable iff (reset)
      (ocState == CFE_RETRY && retryCount == RETRY_CYC - 32'h1) |=> ocState == CFE_RUN;
  endproperty
  a_retry_back: assert property (p_retry_back)
    else $error("Over-current retry did not restart.");

  property p_latch_holds;
    @(posedge clock) disable iff (reset)
      (ovState == CFE_LATCHED && !latchClear) |=> ovState == CFE_LATCHED;
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("Latched fault released without enable toggle.");

  property p_ov_mode;
    @(posedge clock) disable iff (reset)
      (ovState == CFE_RUN && ovTrip) |=>
        ovState == ($past(ctrl[`CFE_CTRL_OVLATCH]) ? CFE_LATCHED : CFE_RETRY);
  endproperty
  a_ov_mode: assert property (p_ov_mode)
    else $error("Over-voltage entered the wrong mode.");

  property p_ot_recover;
    @(posedge clock) disable iff (reset)
      (otState == CFE_RETRY && !otTrip) |=> otState == CFE_RUN;
  endproperty
  a_ot_recover: assert property (p_ot_recover)
    else $error("Over-temperature did not auto-recover.");

  property p_gate;
    @(posedge clock) disable iff (reset)
      outputEnable |-> $past(priActive && secActive && !ocTrip && !ovTrip && !otTrip &&
                             ocState == CFE_RUN && ovState == CFE_RUN && otState == CFE_RUN);
  endproperty
  a_gate: assert property (p_gate)
    else $error("Output enabled without permission.");

  property p_sec_ignored;
    @(posedge clock) disable iff (reset)
      (!ctrl[`CFE_CTRL_SECUSE] && priActive && !faultBlock) |=> outputEnable;
  endproperty
  a_sec_ignored: assert property (p_sec_ignored)
    else $error("Secondary enable gated while ignored.");

  property p_pri_pol;
    @(posedge clock) disable iff (reset)
      (priIf.stable != ctrl[`CFE_CTRL_PRIPOS]) |=> !outputEnable;
  endproperty
  a_pri_pol: assert property (p_pri_pol)
    else $error("Primary polarity wrong.");
endmodule

// ===== verif/cfe_sys_ctrl.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// System controller model: drives both enable pins and masters the register bus.
// ----------------------------------------------------------------
module cfe_sys_ctrl
(
  input wire logic clock,
  output logic primaryEnablePin,
  output logic secondaryEnableInput,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Both pins start low, which reads as enabled under the default polarity.
  initial
  begin
    primaryEnablePin = 1'b0;
    secondaryEnableInput = 1'b0;
    s_axi_awaddr = 32'h0000_0000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h0000_0000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // Pins change just after an edge, like every other request.
  task automatic setPins(input logic pri, input logic sec);
    @(posedge clock);
    primaryEnablePin <= pri;
    secondaryEnableInput <= sec;
  endtask

  // Holds the primary pin inactive for a span, then makes it active again.
  task automatic holdPrimary(input logic offLevel, input int cyc);
    setPins(offLevel, secondaryEnableInput);
    repeat (cyc) @(posedge clock);
    setPins(~offLevel, secondaryEnableInput);
  endtask

  // Address and data are offered together; each is released when taken.
  task automatic axiWrite(input logic [31:0] addr, input logic [31:0] data,
                          output logic [1:0] resp);
    @(posedge clock);
    s_axi_awaddr <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Stale payload is scrambled so the slave cannot lean on it.
    s_axi_awaddr <= ~addr;
    s_axi_wdata <= ~data;
  endtask

  // The address is released once taken; the data is taken when the answer stands.
  task automatic axiRead(input logic [31:0] addr, output logic [31:0] data,
                         output logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    s_axi_araddr <= ~addr;
  endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
`include "cfe_params.svh"
module testbench;
  // Short counts keep the run brief; the filter, retry and latch waits below derive from them.
  localparam logic [31:0] FILT = 32'd4;
  localparam logic [31:0] LATCH = 32'd20;
  localparam logic [31:0] RETRY = 32'd10;
  localparam logic [31:0] A_CTRL = 32'(`CFE_OFS_CTRL);
  localparam logic [31:0] A_OCTH = 32'(`CFE_OFS_OCTH);
  localparam logic [31:0] A_OVTH = 32'(`CFE_OFS_OVTH);
  localparam logic [31:0] A_OTTH = 32'(`CFE_OFS_OTTH);
  localparam logic [31:0] A_STAT = 32'(`CFE_OFS_STAT);
  localparam logic [31:0] A_IRQS = 32'(`CFE_OFS_IRQS);
  localparam logic [31:0] A_IRQM = 32'(`CFE_OFS_IRQM);
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [15:0] outputCurrent, outputVoltage, moduleTemp;
  logic primaryEnablePin, secondaryEnableInput, outputEnable, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int errors = 0;
  int checks = 0;

  // ----------------------------------------------------------------
  // Clock, design and controller model.
  // ----------------------------------------------------------------
  always #10 clock = ~clock;

  cfe_top #(.FILT_CYC(FILT), .LATCH_CYC(LATCH), .RETRY_CYC(RETRY)) dut_u (.clock, .reset,
    .primaryEnablePin, .secondaryEnableInput, .outputCurrent, .outputVoltage, .moduleTemp,
    .outputEnable, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  cfe_sys_ctrl partner_u (.clock, .primaryEnablePin, .secondaryEnableInput, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // ----------------------------------------------------------------
  // Checking helpers.
  // ----------------------------------------------------------------
  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Waits a bounded number of cycles for the output to reach a level.
  task automatic waitOut(input logic exp, input int maxCyc);
    int n = 0;
    while (outputEnable !== exp && n < maxCyc)
    begin
      @(negedge clock);
      n++;
    end
    cmpWord({31'h0, outputEnable}, {31'h0, exp});
  endtask

  // The output must not leave a level at any settled point of the span.
  task automatic holdOut(input logic exp, input int cyc);
    logic [31:0] moved = 32'h0;
    repeat (cyc)
    begin
      @(negedge clock);
      if (outputEnable !== exp)
        moved = 32'h1;
    end
    cmpWord(moved, 32'h0);
  endtask

  task automatic readChk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic [31:0] got;
    logic [1:0] resp;
    partner_u.axiRead(a, got, resp);
    cmpWord(got, d);
    cmpWord({30'h0, resp}, {30'h0, r});
  endtask

  task automatic writeReg(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic [1:0] resp;
    partner_u.axiWrite(a, d, resp);
    cmpWord({30'h0, resp}, {30'h0, r});
  endtask

  task automatic setMeas(input logic [15:0] cur, input logic [15:0] volt, input logic [15:0] t);
    @(posedge clock);
    outputCurrent <= cur;
    outputVoltage <= volt;
    moduleTemp <= t;
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic defaultsTest();
    readChk(A_CTRL, 32'(`CFE_CTRL_RESET), 2'd0);
    readChk(A_OCTH, 32'h0000_FFFF, 2'd0);
    readChk(A_OVTH, 32'h0000_FFFF, 2'd0);
    readChk(A_OTTH, 32'h0000_FFFF, 2'd0);
    readChk(32'h0000_0020, 32'h0, 2'd2);
    writeReg(32'h0000_0020, 32'h1, 2'd2);
    waitOut(1'b1, 20);
  endtask

  // A short pulse is ignored; a held level acts.
  task automatic glitchTest();
    partner_u.setPins(1'b1, 1'b0);
    repeat (FILT / 2) @(posedge clock);
    partner_u.setPins(1'b0, 1'b0);
    holdOut(1'b1, 20);
    partner_u.setPins(1'b1, 1'b0);
    waitOut(1'b0, 20);
    partner_u.setPins(1'b0, 1'b0);
    waitOut(1'b1, 20);
  endtask

  task automatic overCurrentTest();
    writeReg(A_IRQM, 32'h1, 2'd0);
    writeReg(A_OCTH, 32'h0064, 2'd0);
    setMeas(16'h0065, 16'h0000, 16'h0000);
    waitOut(1'b0, 3);
    // An output that is off carries no load, so the reading falls away.
    setMeas(16'h0000, 16'h0000, 16'h0000);
    waitOut(1'b1, 3 * RETRY);
    setMeas(16'h0065, 16'h0000, 16'h0000);
    waitOut(1'b0, 3);
    readChk(A_STAT, 32'h1, 2'd0);
    setMeas(16'h0064, 16'h0000, 16'h0000);
    waitOut(1'b1, 3 * RETRY);
    holdOut(1'b1, 20);
    cmpWord({31'h0, irq}, 32'h1);
    readChk(A_IRQS, 32'h1, 2'd0);
    writeReg(A_IRQS, 32'h1, 2'd0);
    repeat (2) @(negedge clock);
    cmpWord({31'h0, irq}, 32'h0);
    readChk(A_IRQS, 32'h0, 2'd0);
  endtask

  task automatic overVoltageLatchTest();
    writeReg(A_CTRL, 32'h02, 2'd0);
    readChk(A_CTRL, 32'h02, 2'd0);
    writeReg(A_OVTH, 32'h0200, 2'd0);
    setMeas(16'h0000, 16'h0201, 16'h0000);
    waitOut(1'b0, 3);
    setMeas(16'h0000, 16'h0000, 16'h0000);
    holdOut(1'b0, 3 * RETRY);
    // This fault is masked, so the line stays quiet while the bit is set.
    cmpWord({31'h0, irq}, 32'h0);
    readChk(A_IRQS, 32'h2, 2'd0);
    partner_u.holdPrimary(1'b1, LATCH / 2);
    holdOut(1'b0, 20);
    partner_u.holdPrimary(1'b1, LATCH + FILT + 10);
    waitOut(1'b1, FILT + 20);
    writeReg(A_IRQS, 32'h2, 2'd0);
  endtask

  task automatic overTempTest();
    writeReg(A_CTRL, 32'h00, 2'd0);
    writeReg(A_OTTH, 32'h0032, 2'd0);
    setMeas(16'h0000, 16'h0000, 16'h0033);
    waitOut(1'b0, 3);
    holdOut(1'b0, 3 * RETRY);
    setMeas(16'h0000, 16'h0000, 16'h0032);
    waitOut(1'b1, 5);
    writeReg(A_CTRL, 32'h04, 2'd0);
    setMeas(16'h0000, 16'h0000, 16'h0033);
    waitOut(1'b0, 3);
    setMeas(16'h0000, 16'h0000, 16'h0000);
    holdOut(1'b0, 3 * RETRY);
    partner_u.holdPrimary(1'b1, LATCH + FILT + 10);
    waitOut(1'b1, FILT + 20);
  endtask

  task automatic polarityTest();
    writeReg(A_CTRL, 32'h08, 2'd0);
    waitOut(1'b0, 20);
    partner_u.setPins(1'b1, 1'b1);
    waitOut(1'b1, 20);
    writeReg(A_CTRL, 32'h18, 2'd0);
    waitOut(1'b0, 20);
    writeReg(A_CTRL, 32'h38, 2'd0);
    waitOut(1'b1, 20);
    partner_u.setPins(1'b1, 1'b0);
    waitOut(1'b0, 20);
    writeReg(A_CTRL, 32'h08, 2'd0);
    waitOut(1'b1, 20);
  endtask

  task automatic final_report();
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------
  initial
  begin
    outputCurrent = 16'h0000;
    outputVoltage = 16'h0000;
    moduleTemp = 16'h0000;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    defaultsTest();
    glitchTest();
    overCurrentTest();
    overVoltageLatchTest();
    overTempTest();
    polarityTest();
    final_report();
  end

  // The tests need well under a thousand cycles; twenty thousand means a hang.
  initial
  begin
    #400000;
    errors++;
    final_report();
  end
endmodule
